// [verilog/dsw_pkg.sv]
// constants and types for the drive status word flag block
// Operation
// - voltage enabled set while main power applied
// - quick stop bit low while stopping
// - warning bit follows warning, no state change
// - bit eight always reads zero
// - remote set in preop, safeop and op, clear in init and boot
// - bits 13,12,10 depend on mode
// - follow, following error, homing flag meanings
// - limit bit set on any applicable factor
// - factor set depends on mode, servo state
// - estop ignored when torque stays unlimited
// - zero torque limit sets flag always
// - torque limit is smallest candidate value
// - torque modes add command sum candidate
// - second limit only for selection 2/4, never in torque modes
// - judgment option includes or excludes command
// - bits fifteen and fourteen read zero
// - drive state encoded in bits 6,5,3-0
package dsw_pkg;
    localparam logic [15:0] DSW_IDX_STATUS = 16'h6041;
    localparam logic [15:0] DSW_IDX_JUDGE  = 16'h3703;
    localparam logic [15:0] DSW_JUDGE_MAX  = 16'h0001;
    localparam logic        DSW_JUDGE_RST  = 1'b0;
    localparam logic [15:0] DSW_STATUS_RST = 16'h0000;
    localparam int DSW_BIT_VE  = 4;
    localparam int DSW_BIT_QS  = 5;
    localparam int DSW_BIT_W   = 7;
    localparam int DSW_BIT_R8  = 8;
    localparam int DSW_BIT_RM  = 9;
    localparam int DSW_BIT_M10 = 10;
    localparam int DSW_BIT_ILA = 11;
    localparam int DSW_BIT_M12 = 12;
    localparam int DSW_BIT_M13 = 13;
    localparam logic [7:0] DSW_MODE_PP  = 8'h01;
    localparam logic [7:0] DSW_MODE_PV  = 8'h03;
    localparam logic [7:0] DSW_MODE_TQ  = 8'h04;
    localparam logic [7:0] DSW_MODE_HM  = 8'h06;
    localparam logic [7:0] DSW_MODE_IP  = 8'h07;
    localparam logic [7:0] DSW_MODE_CSP = 8'h08;
    localparam logic [7:0] DSW_MODE_CSV = 8'h09;
    localparam logic [7:0] DSW_MODE_CST = 8'h0a;
    localparam logic [7:0] DSW_LIMSEL_A = 8'h02;
    localparam logic [7:0] DSW_LIMSEL_B = 8'h04;

    typedef enum logic [2:0] {
        DSW_PDS_NOT_READY,
        DSW_PDS_SW_ON_DISABLED,
        DSW_PDS_READY,
        DSW_PDS_SWITCHED_ON,
        DSW_PDS_OP_ENABLED,
        DSW_PDS_QUICK_STOP,
        DSW_PDS_FAULT_REACTION,
        DSW_PDS_FAULT
    } dsw_pds_type;

    typedef enum logic [2:0] {
        DSW_LINK_INIT,
        DSW_LINK_PREOP,
        DSW_LINK_BOOT,
        DSW_LINK_SAFEOP,
        DSW_LINK_OP
    } dsw_link_type;

    typedef struct packed {
        logic target_reached;
        logic following_error;
        logic setpoint_ack;
        logic speed_zero;
        logic homing_error;
        logic homing_attained;
        logic ip_active;
        logic follows_command;
    } dsw_mode_flags_type;

    typedef struct packed {
        logic estop;
        logic estop_torque_free;
        logic overtravel_pos;
        logic overtravel_neg;
        logic soft_limit;
        logic rot_dir_limit;
    } dsw_limit_in_type;

    typedef struct packed {
        logic signed [15:0] target_torque;
        logic signed [15:0] torque_offset;
        logic        [15:0] max_torque;
        logic        [15:0] limit_1;
        logic        [15:0] limit_2;
        logic        [7:0]  limit_select;
    } dsw_torque_type;
endpackage : dsw_pkg

// [verilog/dsw_torque_min.sv]
// effective torque limit: smallest of the candidate limits
`timescale 1ns/1ps
`default_nettype none
module dsw_torque_min (
    input  wire dsw_pkg::dsw_torque_type tq,
    input  wire logic                    torque_mode,
    input  wire logic                    include_cmd,
    output logic [16:0]                  limit
);
    import dsw_pkg::*;
    logic signed [16:0] sum;
    logic [16:0]        sum_mag;
    logic [16:0]        m;
    always_comb begin
        sum = 17'(tq.target_torque) + 17'(tq.torque_offset);
        sum_mag = sum[16] ? 17'(-sum) : 17'(sum);
        // max torque and first limit always count
        m = {1'b0, tq.max_torque};
        if ({1'b0, tq.limit_1} < m) begin
            m = {1'b0, tq.limit_1};
        end
        if (torque_mode && include_cmd && sum_mag < m) begin
            m = sum_mag;
        end
        if (!torque_mode && (tq.limit_select == DSW_LIMSEL_A
                || tq.limit_select == DSW_LIMSEL_B)
                && {1'b0, tq.limit_2} < m) begin
            m = {1'b0, tq.limit_2};
        end
        limit = m;
    end
endmodule : dsw_torque_min
`default_nettype wire

// [verilog/dsw_pds_encode.sv]
// drive state to status word bits 6, 5 and 3..0
`timescale 1ns/1ps
`default_nettype none
module dsw_pds_encode (
    input  wire dsw_pkg::dsw_pds_type state,
    output logic [15:0]               bits
);
    import dsw_pkg::*;
    // don't-care positions are driven as zero, except bit 5 which
    // defaults high so only a real quick stop pulls it low
    always_comb begin
        unique case (state)
            DSW_PDS_NOT_READY:      bits = 16'h0020;
            DSW_PDS_SW_ON_DISABLED: bits = 16'h0060;
            DSW_PDS_READY:          bits = 16'h0021;
            DSW_PDS_SWITCHED_ON:    bits = 16'h0023;
            DSW_PDS_OP_ENABLED:     bits = 16'h0027;
            DSW_PDS_QUICK_STOP:     bits = 16'h0007;
            DSW_PDS_FAULT_REACTION: bits = 16'h002f;
            DSW_PDS_FAULT:          bits = 16'h0028;
        endcase
    end
endmodule : dsw_pds_encode
`default_nettype wire

// [verilog/dsw_status_word.sv]
// drive status word generation with object read/write access
`timescale 1ns/1ps
`default_nettype none
module dsw_status_word (
    input  wire logic                         clk,
    input  wire logic                         reset,
    input  wire logic                         ce,
    input  wire dsw_pkg::dsw_pds_type         pds_state,
    input  wire dsw_pkg::dsw_link_type        link_state,
    input  wire logic                         main_power_on,
    input  wire logic                         quick_stop_active,
    input  wire logic                         warning_present,
    input  wire logic                         servo_on,
    input  wire logic [7:0]                   op_mode,
    input  wire dsw_pkg::dsw_mode_flags_type  mode_flags,
    input  wire dsw_pkg::dsw_limit_in_type    limit_in,
    input  wire dsw_pkg::dsw_torque_type      torque_in,
    input  wire logic [15:0]                  torque_output,
    input  wire logic                         obj_req,
    input  wire logic                         obj_write,
    input  wire logic [15:0]                  obj_index,
    input  wire logic [15:0]                  obj_wdata,
    output logic                              obj_ack,
    output logic                              obj_err,
    output logic [15:0]                       obj_rdata,
    output logic [15:0]                       drive_status_word,
    output logic [16:0]                       torque_limit,
    output logic                              judgment_exclude
);
    import dsw_pkg::*;

    // mode decode
    logic        mode_pp;
    logic        mode_pv;
    logic        mode_tq;
    logic        mode_hm;
    logic        mode_ip;
    logic        mode_csp;
    logic        mode_csv;
    logic        mode_cst;
    logic        pos_mode;
    logic        torque_mode;
    logic        cyclic_mode;

    // limit factor terms
    logic        estop_f;
    logic        torque_f;
    logic        ot_f;
    logic        soft_f;
    logic        rot_f;
    logic        at_limit;
    logic [16:0] limit_now;

    // status word assembly
    logic [15:0] pds_bits;
    logic        bit10_d;
    logic        bit12_d;
    logic        bit13_d;
    logic        ila_d;
    logic        remote_d;
    logic [15:0] status_d;

    // registers
    logic [15:0] status_q;
    logic [16:0] limit_q;
    logic        judge_q;
    logic        ack_q;
    logic        err_q;
    logic [15:0] rdata_q;

    // object access decode
    logic        hit_status;
    logic        hit_judge;
    logic        judge_ok;

    assign mode_pp     = (op_mode == DSW_MODE_PP);
    assign mode_pv     = (op_mode == DSW_MODE_PV);
    assign mode_tq     = (op_mode == DSW_MODE_TQ);
    assign mode_hm     = (op_mode == DSW_MODE_HM);
    assign mode_ip     = (op_mode == DSW_MODE_IP);
    assign mode_csp    = (op_mode == DSW_MODE_CSP);
    assign mode_csv    = (op_mode == DSW_MODE_CSV);
    assign mode_cst    = (op_mode == DSW_MODE_CST);
    assign pos_mode    = mode_pp | mode_csp;
    assign torque_mode = mode_tq | mode_cst;
    assign cyclic_mode = mode_csp | mode_csv | mode_cst;

    dsw_torque_min u_torque_min (
        .tq          (torque_in),
        .torque_mode (torque_mode),
        .include_cmd (!judge_q),
        .limit       (limit_now)
    );

    dsw_pds_encode u_pds_encode (
        .state (pds_state),
        .bits  (pds_bits)
    );

    // the output is judged against the limit actually in force; with
    // the exclude option the command sum simply never enters the minimum
    assign at_limit = ({1'b0, torque_output} >= limit_now);

    always_comb begin
        // estop counts only with servo on and only when it clamps torque
        estop_f = limit_in.estop && !limit_in.estop_torque_free
                  && servo_on;
        // a zero limit counts even with the servo off
        torque_f = (at_limit && servo_on)
                   || (limit_now == 17'h00000);
        ot_f = (limit_in.overtravel_pos || limit_in.overtravel_neg)
               && !mode_hm;
        soft_f = limit_in.soft_limit && pos_mode;
        rot_f = limit_in.rot_dir_limit && torque_mode && servo_on;
        ila_d = estop_f || torque_f || ot_f || soft_f || rot_f;
    end

    always_comb begin
        bit10_d = 1'b0;
        bit12_d = 1'b0;
        bit13_d = 1'b0;
        // unused positions per mode are driven low rather than left open
        if (mode_pp || mode_pv || mode_tq || mode_hm || mode_ip) begin
            bit10_d = mode_flags.target_reached;
        end
        if (cyclic_mode) begin
            bit12_d = mode_flags.follows_command;
        end else if (mode_pp) begin
            bit12_d = mode_flags.setpoint_ack;
        end else if (mode_pv) begin
            bit12_d = mode_flags.speed_zero;
        end else if (mode_ip) begin
            bit12_d = mode_flags.ip_active;
        end else if (mode_hm) begin
            bit12_d = mode_flags.homing_attained;
        end
        if (pos_mode) begin
            bit13_d = mode_flags.following_error;
        end else if (mode_hm) begin
            bit13_d = mode_flags.homing_error;
        end
    end

    assign remote_d = (link_state == DSW_LINK_PREOP)
                      || (link_state == DSW_LINK_SAFEOP)
                      || (link_state == DSW_LINK_OP);

    always_comb begin
        status_d = pds_bits;
        status_d[DSW_BIT_VE] = main_power_on;
        if (quick_stop_active) begin
            status_d[DSW_BIT_QS] = 1'b0;
        end
        // warning is reported only; the drive state is left alone
        status_d[DSW_BIT_W]   = warning_present;
        status_d[DSW_BIT_R8]  = 1'b0;
        status_d[DSW_BIT_RM]  = remote_d;
        status_d[DSW_BIT_M10] = bit10_d;
        status_d[DSW_BIT_ILA] = ila_d;
        status_d[DSW_BIT_M12] = bit12_d;
        status_d[DSW_BIT_M13] = bit13_d;
        status_d[15:14]       = 2'b00;
    end

    // one refresh per control cycle keeps the next transmit data current
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            status_q <= DSW_STATUS_RST;
        end else if (ce) begin
            status_q <= status_d;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            limit_q <= 17'h00000;
        end else if (ce) begin
            limit_q <= limit_now;
        end
    end

    assign hit_status = (obj_index == DSW_IDX_STATUS);
    assign hit_judge  = (obj_index == DSW_IDX_JUDGE);
    assign judge_ok   = (obj_wdata <= DSW_JUDGE_MAX);

    // out-of-range judgment values are refused and the old value kept
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            judge_q <= DSW_JUDGE_RST;
        end else if (ce && obj_req && obj_write && hit_judge
                     && judge_ok) begin
            judge_q <= obj_wdata[0];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ack_q <= 1'b0;
        end else if (ce) begin
            ack_q <= obj_req;
        end
    end

    // status word is read only; writes to it or to unknown indexes fail
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            err_q <= 1'b0;
        end else if (ce) begin
            if (!obj_req) begin
                err_q <= 1'b0;
            end else if (obj_write) begin
                err_q <= !(hit_judge && judge_ok);
            end else begin
                err_q <= !(hit_status || hit_judge);
            end
        end
    end

    // reads return the freshest word, not the one a cycle old
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_q <= 16'h0000;
        end else if (ce) begin
            if (obj_req && !obj_write && hit_status) begin
                rdata_q <= status_d;
            end else if (obj_req && !obj_write && hit_judge) begin
                rdata_q <= {15'h0000, judge_q};
            end else begin
                rdata_q <= 16'h0000;
            end
        end
    end

    assign drive_status_word = status_q;
    assign torque_limit      = limit_q;
    assign judgment_exclude  = judge_q;
    assign obj_ack           = ack_q;
    assign obj_err           = err_q;
    assign obj_rdata         = rdata_q;
endmodule : dsw_status_word
`default_nettype wire

// [testbench/dsw_status_word_props.sv]
// port assertions for the drive status word block
`timescale 1ns/1ps
`default_nettype none
module dsw_status_word_props import dsw_pkg::*; (
    input wire logic             clk,
    input wire logic             reset,
    input wire logic             ce,
    input wire dsw_link_type     link_state,
    input wire logic             main_power_on,
    input wire logic             quick_stop_active,
    input wire logic             warning_present,
    input wire logic             servo_on,
    input wire dsw_limit_in_type limit_in,
    input wire dsw_torque_type   torque_in,
    input wire logic             obj_req,
    input wire logic             obj_write,
    input wire logic [15:0]      obj_index,
    input wire logic [15:0]      obj_wdata,
    input wire logic             obj_ack,
    input wire logic             obj_err,
    input wire logic [15:0]      obj_rdata,
    input wire logic [15:0]      drive_status_word,
    input wire logic [16:0]      torque_limit,
    input wire logic             judgment_exclude
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // high once the word was loaded at the previous edge, so reset zeros are skipped
    logic live_q;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) live_q <= 1'b0;
        else live_q <= ce;
    end
    sequence s_rd;
        ce && obj_req && !obj_write && obj_index == DSW_IDX_STATUS;
    endsequence
    sequence s_wj;
        ce && obj_req && obj_write && obj_index == DSW_IDX_JUDGE && obj_wdata <= DSW_JUDGE_MAX;
    endsequence
    AST_RSV: assert property (drive_status_word[15:14] == 2'b00 && !drive_status_word[8])
        else $error("reserved status bits set");
    AST_VOLT: assert property (live_q |-> drive_status_word[4] == $past(main_power_on))
        else $error("voltage flag wrong");
    AST_QS: assert property (live_q |-> drive_status_word[5] == !$past(quick_stop_active))
        else $error("quick stop flag wrong");
    AST_WARN: assert property (live_q |-> drive_status_word[7] == $past(warning_present))
        else $error("warning flag wrong");
    AST_REMOTE: assert property (live_q |-> drive_status_word[9] ==
        ($past(link_state) inside {DSW_LINK_PREOP, DSW_LINK_SAFEOP, DSW_LINK_OP}))
        else $error("remote flag wrong");
    AST_ESTOP: assert property (live_q && $past(servo_on) && $past(limit_in.estop) &&
        !$past(limit_in.estop_torque_free) |-> drive_status_word[11])
        else $error("estop limit flag missing");
    AST_ZERO: assert property (live_q && torque_limit == 17'h00000 |-> drive_status_word[11])
        else $error("zero limit flag missing");
    AST_MIN: assert property (live_q |-> torque_limit <= {1'b0, $past(torque_in.max_torque)}
        && torque_limit <= {1'b0, $past(torque_in.limit_1)})
        else $error("torque limit above fixed candidates");
    AST_RD: assert property (s_rd |=> obj_ack && !obj_err && obj_rdata == drive_status_word)
        else $error("status read wrong");
    AST_WJ: assert property (s_wj |=> obj_ack && !obj_err && judgment_exclude == $past(obj_wdata[0]))
        else $error("judgment write wrong");
endmodule : dsw_status_word_props
bind dsw_status_word dsw_status_word_props u_props (.*);
`default_nettype wire

// [testbench/dsw_master_model.sv]
// fieldbus master model making object reads and writes
`timescale 1ns/1ps
`default_nettype none
module dsw_master_model (
    input  wire logic        clk,
    input  wire logic        obj_ack,
    input  wire logic        obj_err,
    input  wire logic [15:0] obj_rdata,
    output logic             obj_req,
    output logic             obj_write,
    output logic      [15:0] obj_index,
    output logic      [15:0] obj_wdata
);
    initial begin
        obj_req = 1'b0;
        obj_write = 1'b0;
        obj_index = 16'h0000;
        obj_wdata = 16'h0000;
    end
    // one access per call; idle lines show inverted values so stale data never matches
    task automatic access(input logic w, input logic [15:0] i, input logic [15:0] d,
                          output logic [15:0] rd, output logic [1:0] e);
        @(posedge clk);
        obj_req <= 1'b1;
        obj_write <= w;
        obj_index <= i;
        obj_wdata <= d;
        @(posedge clk);
        obj_req <= 1'b0;
        obj_write <= ~w;
        obj_index <= ~i;
        obj_wdata <= ~d;
        // the answer stands for the cycle after the edge that took the request
        @(posedge clk);
        e = {obj_ack, obj_err};
        rd = obj_rdata;
    endtask : access
endmodule : dsw_master_model
`default_nettype wire

// [testbench/dsw_status_word_tb.sv]
// self-checking bench for the drive status word block
`timescale 1ns/1ps
`default_nettype none
module dsw_status_word_tb;
    import dsw_pkg::*;
    logic clk, reset, ce, pwr, qs, warn, son, req, wr, ack, oerr, jx;
    dsw_pds_type        pds;
    dsw_link_type       lnk;
    logic [7:0]         mode;
    dsw_mode_flags_type mf;
    dsw_limit_in_type   li;
    dsw_torque_type     ti;
    logic [15:0]        tout, idx, wd, rd, sw;
    logic [16:0]        tl;
    int                 err_count, tests_run, cyc;
    localparam logic [21:0] ST_T [3] = '{22'h240237, 22'h2b0287, 22'h3c0238};
    localparam logic [18:0] MD_T [11] = '{{DSW_MODE_PP, 8'h80, 3'h1}, {DSW_MODE_PP, 8'h40, 3'h4},
        {DSW_MODE_PP, 8'h20, 3'h2}, {DSW_MODE_PV, 8'h10, 3'h2}, {DSW_MODE_TQ, 8'h80, 3'h1},
        {DSW_MODE_HM, 8'h08, 3'h4}, {DSW_MODE_HM, 8'h04, 3'h2}, {DSW_MODE_IP, 8'h02, 3'h2},
        {DSW_MODE_CSP, 8'h41, 3'h6}, {DSW_MODE_CSV, 8'h01, 3'h2}, {DSW_MODE_CST, 8'h81, 3'h2}};
    localparam logic [15:0] LM_T [10] = '{{DSW_MODE_CSP, 8'hc1}, {DSW_MODE_CSP, 8'h40},
        {DSW_MODE_CSP, 8'he0}, {DSW_MODE_HM, 8'h90}, {DSW_MODE_PV, 8'h09}, {DSW_MODE_PV, 8'h84},
        {DSW_MODE_CSP, 8'h05}, {DSW_MODE_CST, 8'h83}, {DSW_MODE_CSP, 8'h82}, {DSW_MODE_TQ, 8'h02}};
    localparam logic [64:0] TQ_T [8] = '{{DSW_MODE_CSP, 8'h00, 32'h012c0000, 17'h00320},
        {DSW_MODE_CSP, 8'h02, 32'h012c0000, 17'h001f4}, {DSW_MODE_CSP, 8'h04, 32'h012c0000, 17'h001f4},
        {DSW_MODE_CSP, 8'h03, 32'h012c0000, 17'h00320}, {DSW_MODE_CST, 8'h02, 32'h012c0064, 17'h00190},
        {DSW_MODE_PV, 8'h00, 32'h012c0064, 17'h00320}, {DSW_MODE_CST, 8'h00, 32'hfd440064, 17'h00258},
        {DSW_MODE_TQ, 8'h00, 32'h012c0064, 17'h00190}};
    dsw_status_word DUT (.clk(clk), .reset(reset), .ce(ce), .pds_state(pds), .link_state(lnk),
        .main_power_on(pwr), .quick_stop_active(qs), .warning_present(warn), .servo_on(son),
        .op_mode(mode), .mode_flags(mf), .limit_in(li), .torque_in(ti), .torque_output(tout),
        .obj_req(req), .obj_write(wr), .obj_index(idx), .obj_wdata(wd), .obj_ack(ack),
        .obj_err(oerr), .obj_rdata(rd), .drive_status_word(sw), .torque_limit(tl),
        .judgment_exclude(jx));
    dsw_master_model u_mst (.clk(clk), .obj_ack(ack), .obj_err(oerr), .obj_rdata(rd),
        .obj_req(req), .obj_write(wr), .obj_index(idx), .obj_wdata(wd));
    always #25 clk = ~clk;
    task automatic chk(input logic [16:0] got, input logic [16:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick
    task automatic t_state();
        foreach (ST_T[i]) begin
            @(posedge clk);
            pds <= dsw_pds_type'(ST_T[i][21:19]);
            {pwr, qs, warn} <= ST_T[i][18:16];
            tick();
            chk({1'b0, sw & 16'hc3ff}, {1'b0, ST_T[i][15:0]}, "state word");
        end
        @(posedge clk);
        pds <= DSW_PDS_OP_ENABLED;
        {pwr, qs, warn} <= 3'b100;
        for (int s = 0; s < 5; s++) begin
            @(posedge clk);
            lnk <= dsw_link_type'(s);
            tick();
            chk(17'(sw[9]), 17'(s == 1 || s > 2), "remote");
        end
        $display("t_state done");
    endtask : t_state
    task automatic t_mode();
        foreach (MD_T[i]) begin
            @(posedge clk);
            {mode, mf} <= MD_T[i][18:3];
            tick();
            chk(17'({sw[13], sw[12], sw[10]}), 17'(MD_T[i][2:0]), "mode bits");
        end
        foreach (LM_T[i]) begin
            @(posedge clk);
            {mode, son, li} <= LM_T[i][15:1];
            mf <= '0;
            tick();
            chk(17'(sw[11]), 17'(LM_T[i][0]), "limit flag");
        end
        @(posedge clk);
        {mode, son, li} <= {DSW_MODE_CSP, 7'h00};
        ti.limit_1 <= 16'h0000;
        tick();
        chk(17'(sw[11]), 17'h00001, "zero limit");
        chk(tl, 17'h00000, "zero limit value");
        $display("t_mode done");
    endtask : t_mode
    task automatic t_torque();
        @(posedge clk);
        {son, ti.limit_1} <= {1'b1, 16'h0320};
        foreach (TQ_T[i]) begin
            @(posedge clk);
            {mode, ti.limit_select, ti.target_torque, ti.torque_offset} <= TQ_T[i][64:17];
            tick();
            chk(tl, TQ_T[i][16:0], "torque limit");
        end
        @(posedge clk);
        {mode, ti.torque_offset, tout} <= {DSW_MODE_CSP, 32'h00000320};
        tick();
        chk(17'(sw[11]), 17'h00001, "torque at limit");
        @(posedge clk);
        tout <= 16'h031f;
        tick();
        chk(17'(sw[11]), 17'h00000, "torque below limit");
        $display("t_torque done");
    endtask : t_torque
    task automatic t_obj();
        logic [15:0] r;
        logic [1:0] e;
        u_mst.access(1'b0, DSW_IDX_STATUS, 16'h0000, r, e);
        chk(17'(e), 17'h00002, "status read ack");
        chk(17'(r), 17'h00237, "status read data");
        chk(17'(sw), 17'h00237, "status word");
        u_mst.access(1'b1, DSW_IDX_JUDGE, 16'h0001, r, e);
        chk(17'({e, jx}), 17'h00005, "judgment write");
        @(posedge clk);
        {mode, ti.torque_offset} <= {DSW_MODE_CST, 16'h0064};
        u_mst.access(1'b1, DSW_IDX_JUDGE, 16'h0002, r, e);
        chk(17'({e, jx}), 17'h00007, "judgment refused");
        chk(tl, 17'h00320, "sum excluded");
        u_mst.access(1'b0, DSW_IDX_JUDGE, 16'h0000, r, e);
        chk(17'(e), 17'h00002, "judgment read ack");
        chk(17'(r), 17'h00001, "judgment read data");
        u_mst.access(1'b1, DSW_IDX_STATUS, 16'h0000, r, e);
        chk(17'(e), 17'h00003, "status write refused");
        u_mst.access(1'b0, 16'h1234, 16'h0000, r, e);
        chk(17'(e), 17'h00003, "unmapped read");
        u_mst.access(1'b1, DSW_IDX_JUDGE, 16'h0000, r, e);
        chk(17'({e, jx}), 17'h00004, "judgment cleared");
        tick();
        chk(tl, 17'h00190, "sum included again");
        $display("t_obj done");
    endtask : t_obj
    task automatic t_hold();
        @(posedge clk);
        {ce, warn} <= 2'b01;
        tick();
        chk(17'(sw[7]), 17'h00000, "word frozen while ce low");
        @(posedge clk);
        ce <= 1'b1;
        tick();
        chk(17'(sw[7]), 17'h00001, "word refreshed after ce");
        @(posedge clk);
        warn <= 1'b0;
        $display("t_hold done");
    endtask : t_hold
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run
    // a hang in the bench or the master costs a mismatch, not an endless run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_count++;
            complete_run();
        end
    end
    initial begin
        {clk, reset, pwr, qs, warn, son} = 6'h33;
        {err_count, tests_run, cyc} = '0;
        ce = 1'b1;
        pds = DSW_PDS_OP_ENABLED;
        lnk = DSW_LINK_OP;
        {mode, mf, li, tout} = {DSW_MODE_CSP, 30'h0};
        ti = '{16'h012c, 16'h0000, 16'h03e8, 16'h0320, 16'h01f4, 8'h00};
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        t_state();
        t_mode();
        t_torque();
        t_obj();
        t_hold();
        complete_run();
    end
endmodule : dsw_status_word_tb
`default_nettype wire
